// ### logic/eif_pkg.sv
// Package for the two-channel external interrupt edge and noise filter block.
// Assumes one synchronous clock domain (mclk) and a simple strobe register port.
package eif_pkg;

    // Register byte addresses.
    localparam logic [11:0] EIF_CTRL2_ADDR = 12'h0fd9;
    localparam logic [11:0] EIF_CTRL3_ADDR = 12'h0fda;
    localparam logic [11:0] EIF_IRQ_STAT_ADDR = 12'h0fe0;
    localparam logic [11:0] EIF_IRQ_EN_ADDR = 12'h0fe1;
    localparam logic [11:0] EIF_IRQ_CLR_ADDR = 12'h0fe2;

    // Control register field positions.
    localparam int EIF_NC_LSB = 0;
    localparam int EIF_ES_LSB = 2;
    localparam int EIF_LVL_BIT = 4;
    localparam logic [7:0] EIF_CTRL_RESET = 8'h00;
    localparam logic [1:0] EIF_IRQ_RESET = 2'h0;

    // Trigger condition codes.
    localparam logic [1:0] EIF_ES_RISE = 2'h0;
    localparam logic [1:0] EIF_ES_FALL = 2'h1;
    localparam logic [1:0] EIF_ES_BOTH = 2'h2;

    // Sampling dividers of the gear clock, and the low-speed divider of the slow clock.
    localparam logic [3:0] EIF_DIV_NC00 = 4'h0;
    localparam logic [3:0] EIF_DIV_NC01 = 4'h3;
    localparam logic [3:0] EIF_DIV_NC10 = 4'h7;
    localparam logic [3:0] EIF_DIV_NC11 = 4'hf;
    localparam logic [1:0] EIF_DIV_SLOW = 2'h3;

    // Samples that must agree before the filtered level follows the pin.
    localparam logic [1:0] EIF_AGREE = 2'h2;

    typedef struct packed {
        logic [1:0] trigger_select;
        logic [1:0] filter_interval;
    } eif_cfg_s;

    typedef struct packed {
        logic request;
        logic level;
    } eif_evt_s;

endpackage : eif_pkg

// ### logic/eif_noise_filter.sv
// Noise canceller for one external interrupt pin.
// Assumes the pin and the clock ticks are synchronous to mclk.
`timescale 1ns/10ps
module eif_noise_filter
    import eif_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic sample_tick,
    input wire logic pin,
    output logic filtered
);

    logic [1:0] agree;
    logic [1:0] next_agree;
    logic next_filtered;

    // A level must be seen on consecutive sample ticks before it passes,
    // so a glitch shorter than the sampling interval is dropped.
    always_comb
    begin
        next_agree = agree;
        next_filtered = filtered;
        if (sample_tick)
        begin
            if (pin == filtered)
            begin
                next_agree = 2'h0;
            end
            else if (agree == EIF_AGREE - 2'h1)
            begin
                next_filtered = pin;
                next_agree = 2'h0;
            end
            else
            begin
                next_agree = agree + 2'h1;
            end
        end
    end

    // Registers only.
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            agree <= 2'h0;
            filtered <= 1'b0;
        end
        else
        begin
            agree <= next_agree;
            filtered <= next_filtered;
        end
    end

endmodule : eif_noise_filter

// ### logic/eif_edge_detect.sv
// Edge detector and level capture for one channel.
// Assumes the filtered level comes from a register in the mclk domain.
`timescale 1ns/10ps
module eif_edge_detect
    import eif_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [1:0] trigger_select,
    input wire logic filtered,
    output eif_evt_s evt
);

    logic prev;
    logic hit;
    logic next_level;

    // Edge decode on the previous and present filtered level.
    always_comb
    begin
        hit = 1'b0;
        unique case (trigger_select)
            EIF_ES_RISE: hit = filtered & ~prev;
            EIF_ES_FALL: hit = ~filtered & prev;
            EIF_ES_BOTH: hit = filtered ^ prev;
            default: hit = 1'b0;
        endcase
        next_level = evt.level;
        if (hit)
        begin
            next_level = filtered;
        end
    end

    // The request is a registered single pulse, at most one per edge.
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            prev <= 1'b0;
            evt <= '0;
        end
        else
        begin
            prev <= filtered;
            evt.request <= hit;
            evt.level <= next_level;
        end
    end

endmodule : eif_edge_detect

// ### logic/eif_top.sv
// Top of the external interrupt block for channels 2 and 3: register port,
// sampling clocks, filters, edge detectors and a sticky interrupt status.
// Assumes gear_tick and slow_tick are one-cycle strobes synchronous to mclk.
//
// Functional notes
// - Level bit reads 0 after reset.
// - Code 00 requests on rising edges.
// - Code 01 requests on falling edges.
// - Code 10 both edges; 11 reserved.
// - Fast modes sample gear, /4, /8, /16.
// - Slow modes always sample slow clock /4.
// - Control bits 7 to 5 read zero.
// - Mode changes may give spurious requests.
// - Control writes may raise a request.
// - Level bit updated on each request.
// - Gated channel ignores control writes.
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
module eif_top
    import eif_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic gear_tick,
    input wire logic slow_tick,
    input wire logic low_speed_mode,
    input wire logic [1:0] channel_clock_gate,
    input wire logic [1:0] ext_pin,
    output logic [1:0] irq_request,
    output logic irq
);

    eif_cfg_s cfg [2];
    eif_cfg_s next_cfg [2];
    eif_evt_s evt [2];
    logic [1:0] filtered;
    logic [1:0] sample_tick;
    logic [3:0] gear_div [2];
    logic [3:0] next_gear_div [2];
    logic [1:0] slow_div;
    logic [1:0] next_slow_div;
    logic slow_sample;
    logic [1:0] irq_status;
    logic [1:0] next_irq_status;
    logic [1:0] irq_enable;
    logic [1:0] next_irq_enable;
    logic [7:0] next_rdata;

    // Divider terminal count for a filter interval code.
    function automatic logic [3:0] div_limit(input logic [1:0] nc);
        logic [3:0] lim;
        lim = EIF_DIV_NC00;
        unique case (nc)
            2'h0: lim = EIF_DIV_NC00;
            2'h1: lim = EIF_DIV_NC01;
            2'h2: lim = EIF_DIV_NC10;
            2'h3: lim = EIF_DIV_NC11;
        endcase
        return lim;
    endfunction : div_limit

    // Control register image as software reads it; the top bits stay zero.
    function automatic logic [7:0] ctrl_image(input eif_cfg_s c, input logic lvl);
        logic [7:0] v;
        v = 8'h00;
        v[EIF_NC_LSB +: 2] = c.filter_interval;
        v[EIF_ES_LSB +: 2] = c.trigger_select;
        v[EIF_LVL_BIT] = lvl;
        return v;
    endfunction : ctrl_image

    // Shared slow clock divide by four, used by both channels in low-speed modes.
    always_comb
    begin
        next_slow_div = slow_div;
        slow_sample = 1'b0;
        if (slow_tick)
        begin
            next_slow_div = slow_div + 2'h1;
            slow_sample = (slow_div == EIF_DIV_SLOW);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            slow_div <= 2'h0;
        end
        else
        begin
            slow_div <= next_slow_div;
        end
    end

    // Per-channel datapath: sampling divider, filter and edge detector.
    generate
        for (genvar ch = 0; ch < 2; ch++)
        begin : g_ch
            // Divider on gear ticks; selection follows the mode without resync,
            // so a mode switch can shift or add an edge.
            always_comb
            begin
                next_gear_div[ch] = gear_div[ch];
                sample_tick[ch] = 1'b0;
                if (!channel_clock_gate[ch])
                begin
                    next_gear_div[ch] = 4'h0;
                end
                else if (low_speed_mode)
                begin
                    sample_tick[ch] = slow_sample;
                end
                else if (gear_tick)
                begin
                    if (gear_div[ch] >= div_limit(cfg[ch].filter_interval))
                    begin
                        next_gear_div[ch] = 4'h0;
                        sample_tick[ch] = 1'b1;
                    end
                    else
                    begin
                        next_gear_div[ch] = gear_div[ch] + 4'h1;
                    end
                end
            end

            always_ff @(posedge mclk)
            begin
                if (srst)
                begin
                    gear_div[ch] <= 4'h0;
                end
                else
                begin
                    gear_div[ch] <= next_gear_div[ch];
                end
            end

            eif_noise_filter eif_noise_filter_inst (
                .mclk(mclk),
                .srst(srst),
                .sample_tick(sample_tick[ch]),
                .pin(ext_pin[ch]),
                .filtered(filtered[ch])
            );

            eif_edge_detect eif_edge_detect_inst (
                .mclk(mclk),
                .srst(srst),
                .trigger_select(cfg[ch].trigger_select),
                .filtered(filtered[ch]),
                .evt(evt[ch])
            );

            assign irq_request[ch] = evt[ch].request;
        end
    endgenerate

    // Register writes: control, enable and write-one-to-clear status.
    always_comb
    begin
        next_cfg[0] = cfg[0];
        next_cfg[1] = cfg[1];
        next_irq_enable = irq_enable;
        next_irq_status = irq_status;
        if (reg_write)
        begin
            if (reg_addr == EIF_CTRL2_ADDR && channel_clock_gate[0])
            begin
                next_cfg[0].filter_interval = reg_wdata[EIF_NC_LSB +: 2];
                next_cfg[0].trigger_select = reg_wdata[EIF_ES_LSB +: 2];
            end
            if (reg_addr == EIF_CTRL3_ADDR && channel_clock_gate[1])
            begin
                next_cfg[1].filter_interval = reg_wdata[EIF_NC_LSB +: 2];
                next_cfg[1].trigger_select = reg_wdata[EIF_ES_LSB +: 2];
            end
            if (reg_addr == EIF_IRQ_EN_ADDR)
            begin
                next_irq_enable = reg_wdata[1:0];
            end
            if (reg_addr == EIF_IRQ_CLR_ADDR)
            begin
                next_irq_status = irq_status & ~reg_wdata[1:0];
            end
        end
        // A new event wins over a clear in the same cycle.
        next_irq_status = next_irq_status | {evt[1].request, evt[0].request};
    end

    // Read mux; unmapped and write-only addresses read zero.
    always_comb
    begin
        next_rdata = 8'h00;
        if (reg_read)
        begin
            unique case (reg_addr)
                EIF_CTRL2_ADDR: next_rdata = ctrl_image(cfg[0], evt[0].level);
                EIF_CTRL3_ADDR: next_rdata = ctrl_image(cfg[1], evt[1].level);
                EIF_IRQ_STAT_ADDR: next_rdata = {6'h00, irq_status};
                EIF_IRQ_EN_ADDR: next_rdata = {6'h00, irq_enable};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Register stage for configuration, interrupt state and read data.
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            cfg[0] <= eif_cfg_s'(EIF_CTRL_RESET[3:0]);
            cfg[1] <= eif_cfg_s'(EIF_CTRL_RESET[3:0]);
            irq_enable <= EIF_IRQ_RESET;
            irq_status <= EIF_IRQ_RESET;
            reg_rdata <= 8'h00;
        end
        else
        begin
            cfg[0] <= next_cfg[0];
            cfg[1] <= next_cfg[1];
            irq_enable <= next_irq_enable;
            irq_status <= next_irq_status;
            reg_rdata <= next_rdata;
        end
    end

    // Level interrupt while any enabled status bit is set.
    assign irq = |(irq_status & irq_enable);

endmodule : eif_top

// ### sim/eif_top_properties.sv
// Checker for the external interrupt block, bound to the top module ports.
// Assumes one clock, mclk, and a synchronous active-high srst.
`timescale 1ns/10ps
module eif_top_properties
    import eif_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic gear_tick,
    input wire logic slow_tick,
    input wire logic low_speed_mode,
    input wire logic [1:0] channel_clock_gate,
    input wire logic [1:0] ext_pin,
    input wire logic [1:0] irq_request,
    input wire logic irq
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (srst);

    // Read data and request timing.
    property p_ctrl_hi;
        reg_read && reg_addr[11:1] == 11'h7ec |=> reg_rdata[7:5] == 3'h0;
    endproperty
    property p_rd_idle;
        !$past(reg_read) |-> reg_rdata == 8'h00;
    endproperty
    property p_pulse2;
        irq_request[0] |=> !irq_request[0];
    endproperty
    property p_pulse3;
        irq_request[1] |=> !irq_request[1];
    endproperty
    // Gated channel 3 must have drained its pipeline after four cycles.
    property p_gate;
        !channel_clock_gate[1] [*4] |-> !irq_request[1];
    endproperty
    property p_mask;
        reg_write && reg_addr == EIF_IRQ_EN_ADDR && reg_wdata[1:0] == 2'h0 |=> !irq;
    endproperty
    // Set wins over clear, so only a clear without a request is checked.
    property p_clear;
        reg_write && reg_addr == EIF_IRQ_CLR_ADDR && reg_wdata[1:0] == 2'h3
            && irq_request == 2'h0 |=> !irq;
    endproperty
    property p_irq_cause;
        $rose(irq) |-> $past(irq_request != 2'h0)
            || $past(reg_write && reg_addr == EIF_IRQ_EN_ADDR);
    endproperty

    a_ctrl_hi: assert property (p_ctrl_hi) else $error("ctrl top bits");
    a_rd_idle: assert property (p_rd_idle) else $error("idle rdata");
    a_pulse2: assert property (p_pulse2) else $error("ch2 pulse");
    a_pulse3: assert property (p_pulse3) else $error("ch3 pulse");
    a_gate: assert property (p_gate) else $error("gated request");
    a_mask: assert property (p_mask) else $error("masked irq");
    a_clear: assert property (p_clear) else $error("cleared irq");
    a_irq_cause: assert property (p_irq_cause) else $error("irq cause");

    c_req: cover property (irq_request[0]);
    c_irq: cover property (irq);
    c_slow: cover property (low_speed_mode && irq_request[0]);
endmodule : eif_top_properties

// ### sim/eif_far_end.sv
// Far side model: the external pins and the CPU interrupt latch.
// Assumes pin commands come from the bench; pins move only on mclk.
`timescale 1ns/10ps
module eif_far_end (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [1:0] pin_cmd,
    input wire logic [1:0] irq_request,
    output logic [1:0] ext_pin,
    output logic [7:0] latch_count
);
    // Pins are synchronous, and the latch counts every request pulse.
    // count each pulse
    always_ff @(posedge mclk)
    begin
        ext_pin <= pin_cmd;
        if (srst)
            latch_count <= 8'h00;
        else
            latch_count <= latch_count + 8'(irq_request[0]) + 8'(irq_request[1]);
    end
endmodule : eif_far_end

// ### sim/eif_top_tb.sv
// Testbench for the external interrupt block with its far side model.
// Assumes a 40 MHz mclk and gear clock equal to mclk.
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module eif_top_tb
    import eif_pkg::*;
;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [11:0] reg_addr = 12'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic gear_tick = 1'b1;
    logic slow_tick = 1'b0;
    logic low_speed_mode = 1'b0;
    logic [1:0] channel_clock_gate = 2'h1;
    logic [1:0] pin_cmd = 2'h0;
    logic [1:0] ext_pin;
    logic [1:0] irq_request;
    logic irq;
    logic [7:0] latch_count;
    logic [2:0] div = 3'h0;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;

    eif_top eif_top_inst (.mclk, .srst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .gear_tick, .slow_tick, .low_speed_mode, .channel_clock_gate,
        .ext_pin, .irq_request, .irq);
    eif_far_end eif_far_end_inst (.mclk, .srst, .pin_cmd, .irq_request, .ext_pin,
        .latch_count);

    always #12.5 mclk = ~mclk;

    // Slow clock tick every fifth cycle; a hang ends the run as a failure.
    always @(posedge mclk)
    begin
        div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
        slow_tick <= (div == 3'h4);
        cycles++;
        if (cycles == 10000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    // The trailing delay lets register updates settle before any check.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
        #1;
    endtask : wr

    task automatic chk_rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask : chk_rd

    // Move the ch2 pin, stay quiet for a while, then count the requests.
    // The read-back expectation is built from the control value that the scenario wrote.
    task automatic edge_case(input logic lvl, input int quiet, input logic n_exp,
        input logic [3:0] ctl);
        logic [7:0] c0;
        c0 = latch_count;
        pin_cmd[0] <= lvl;
        repeat (quiet) @(posedge mclk);
        `CHK(latch_count, c0)
        repeat (150) @(posedge mclk);
        `CHK(latch_count, c0 + 8'(n_exp))
        if (n_exp)
            chk_rd(EIF_CTRL2_ADDR, {3'h0, lvl, ctl});
    endtask : edge_case

    task automatic t_regs();
        chk_rd(EIF_CTRL2_ADDR, 8'h00);
        chk_rd(EIF_IRQ_STAT_ADDR, 8'h00);
        chk_rd(12'h0ff0, 8'h00);
        wr(EIF_CTRL3_ADDR, 8'hff);
        chk_rd(EIF_CTRL3_ADDR, 8'h00);
        wr(EIF_CTRL2_ADDR, 8'hff);
        chk_rd(EIF_CTRL2_ADDR, 8'h0f);
        channel_clock_gate <= 2'h3;
        wr(EIF_CTRL3_ADDR, 8'h06);
        chk_rd(EIF_CTRL3_ADDR, 8'h06);
    endtask : t_regs

    // Every trigger code with the enable held off around writes.
    task automatic t_edges();
        for (int es = 0; es < 4; es++)
        begin
            wr(EIF_IRQ_EN_ADDR, 8'h00);
            wr(EIF_CTRL2_ADDR, 8'(es << 2));
            edge_case(1'b1, 0, es == 0 || es == 2, 4'(es << 2));
            edge_case(1'b0, 0, es == 1 || es == 2, 4'(es << 2));
        end
    endtask : t_edges

    task automatic t_irq();
        wr(EIF_IRQ_EN_ADDR, 8'h01);
        chk_rd(EIF_IRQ_STAT_ADDR, 8'h01);
        `CHK(irq, 1'b1)
        wr(EIF_IRQ_EN_ADDR, 8'h00);
        `CHK(irq, 1'b0)
        wr(EIF_IRQ_CLR_ADDR, 8'h03);
        chk_rd(EIF_IRQ_STAT_ADDR, 8'h00);
    endtask : t_irq

    // Slower sampling must hold the request back for two cycles less than the divided interval.
    task automatic t_rate();
        for (int nc = 1; nc < 4; nc++)
        begin
            wr(EIF_CTRL2_ADDR, 8'(nc));
            edge_case(1'b1, (2 << nc) - 2, 1'b1, 4'(nc));
            edge_case(1'b0, 0, 1'b0, 4'(nc));
        end
    endtask : t_rate

    task automatic t_slow();
        wr(EIF_CTRL2_ADDR, 8'h00);
        low_speed_mode <= 1'b1;
        repeat (60) @(posedge mclk);
        wr(EIF_IRQ_CLR_ADDR, 8'h03);
        edge_case(1'b1, 18, 1'b1, 4'h0);
        edge_case(1'b0, 0, 1'b0, 4'h0);
        low_speed_mode <= 1'b0;
        repeat (8) @(posedge mclk);
        wr(EIF_IRQ_CLR_ADDR, 8'h03);
        chk_rd(EIF_IRQ_STAT_ADDR, 8'h00);
    endtask : t_slow

    // Reset for two cycles, then run every scenario.
    initial
    begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        t_regs();
        t_edges();
        t_irq();
        t_rate();
        t_slow();
        tally_and_finish();
    end
endmodule : eif_top_tb

bind eif_top eif_top_properties eif_top_properties_inst (.mclk, .srst, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .gear_tick, .slow_tick,
    .low_speed_mode, .channel_clock_gate, .ext_pin, .irq_request, .irq);
